// ### core/txrxp_pointers.sv
// Descriptor pointer and count registers for the network controller's DMA
// What this block does
// - Transmit descriptor address is upper register on 31:16, current on 15:1.
// - Each descriptor area spans up to 32k words, anywhere in memory.
// - Bit 0 of current descriptor registers marks end of the list.
// - Soft reset clears only sequencer, latched word count and flags; hard reset also loads threshold and sequence and clears read data.
// - Receive descriptor address joins upper and current receive registers.
// - Threshold at or below remaining words keeps next packet in area.
// - Threshold above remaining words sets last-packet flag, fetches resource.
// - Hardware reset loads threshold with 02f8, 760 words.
// - Resource addresses join upper resource register with a lower pointer.
// - Resource start, end, read and write registers store bits 15:1; bit 0 reads zero.
// - Start and end bound area; read and write pointers mark fetch, append.
// - Sequence register holds area count 15:8 and packet count 7:0.
// - Packet count increments once per received packet.
// - Moving to next area clears packet count, increments area count.
// - Sequence becomes zero on hardware reset or zero write.
`timescale 1ns/1ps
module txrxp_pointers (
  input  wire logic        core_clk,
  input  wire logic        reset,
  input  wire logic        soft_reset,
  input  wire logic [4:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  input  wire logic        pkt_received,
  input  wire logic [15:0] remaining_buffer_words,
  input  wire logic        tx_desc_advance,
  input  wire logic [15:0] tx_desc_next,
  input  wire logic        rx_desc_advance,
  input  wire logic [15:0] rx_desc_next,
  input  wire logic        resource_fetched,
  input  wire logic [1:0]  resource_sel,
  output logic      [31:0] tx_desc_addr,
  output logic             tx_list_end,
  output logic      [31:0] rx_desc_addr,
  output logic             rx_list_end,
  output logic      [31:0] resource_addr,
  output logic             last_packet_in_buffer_flag,
  output logic             fetch_resource,
  output logic             resource_empty
);
  ////////////////////////////////////////////////////////////////////////
  // Functions and state
  ////////////////////////////////////////////////////////////////////////

  // Join an upper half and a lower half into a word address, bit 0 forced low
  function automatic logic [31:0] txrxp_join(input logic [15:0] upper,
                                             input logic [15:0] lower);
    txrxp_join = {upper, lower[15:1], 1'b0};
  endfunction

  // Keep only bits 15:1 of a resource register
  function automatic logic [15:0] txrxp_res(input logic [15:0] value);
    txrxp_res = value & txrxp_pkg::TXRXP_RES_MASK;
  endfunction

  typedef enum logic [2:0] {
    TXRXP_IDLE  = 3'b001,
    TXRXP_CHECK = 3'b010,
    TXRXP_FETCH = 3'b100
  } txrxp_state_type;

  logic [15:0]     tx_upper_r;
  logic [15:0]     tx_current_r;
  logic [15:0]     rx_upper_r;
  logic [15:0]     rx_current_r;
  logic [15:0]     eob_count_r;
  logic [15:0]     res_upper_r;
  logic [15:0]     res_start_r;
  logic [15:0]     res_end_r;
  logic [15:0]     res_read_r;
  logic [15:0]     res_write_r;
  logic [15:0]     remain_r;
  logic            last_pkt_r;
  logic            fetch_r;
  logic [15:0]     rdata_r;
  txrxp_state_type state_r;
  txrxp_state_type state_nxt;
  logic [15:0]     seq_value;
  logic [15:0]     res_lower;
  logic [15:0]     res_read_nxt;
  logic [15:0]     rdata_nxt;
  logic            keep_area;
  logic            next_area;
  logic            seq_wr;
  logic            wr_tx_upper;
  logic            wr_tx_current;
  logic            wr_rx_upper;
  logic            wr_rx_current;
  logic            wr_eob;
  logic            wr_res_upper;
  logic            wr_res_start;
  logic            wr_res_end;
  logic            wr_res_read;
  logic            wr_res_write;

  ////////////////////////////////////////////////////////////////////////
  // Write decode
  ////////////////////////////////////////////////////////////////////////

  // One strobe per register from the plain write port
  assign wr_tx_upper   = reg_wr && (reg_addr == txrxp_pkg::TXRXP_OFF_TX_UPPER);
  assign wr_tx_current = reg_wr && (reg_addr == txrxp_pkg::TXRXP_OFF_TX_CURRENT);
  assign wr_rx_upper   = reg_wr && (reg_addr == txrxp_pkg::TXRXP_OFF_RX_UPPER);
  assign wr_rx_current = reg_wr && (reg_addr == txrxp_pkg::TXRXP_OFF_RX_CURRENT);
  assign wr_eob        = reg_wr && (reg_addr == txrxp_pkg::TXRXP_OFF_EOB_COUNT);
  assign wr_res_upper  = reg_wr && (reg_addr == txrxp_pkg::TXRXP_OFF_RES_UPPER);
  assign wr_res_start  = reg_wr && (reg_addr == txrxp_pkg::TXRXP_OFF_RES_START);
  assign wr_res_end    = reg_wr && (reg_addr == txrxp_pkg::TXRXP_OFF_RES_END);
  assign wr_res_read   = reg_wr && (reg_addr == txrxp_pkg::TXRXP_OFF_RES_READ);
  assign wr_res_write  = reg_wr && (reg_addr == txrxp_pkg::TXRXP_OFF_RES_WRITE);
  assign seq_wr        = reg_wr && (reg_addr == txrxp_pkg::TXRXP_OFF_SEQUENCE);

  ////////////////////////////////////////////////////////////////////////
  // Address registers
  ////////////////////////////////////////////////////////////////////////

  // Descriptor addresses hold through both resets; the DMA may advance them
  always_ff @(posedge core_clk) begin
    if (wr_tx_upper) tx_upper_r <= reg_wdata;
    if (wr_tx_current) tx_current_r <= reg_wdata;
    else if (tx_desc_advance) tx_current_r <= tx_desc_next;
    if (wr_rx_upper) rx_upper_r <= reg_wdata;
    if (wr_rx_current) rx_current_r <= reg_wdata;
    else if (rx_desc_advance) rx_current_r <= rx_desc_next;
    if (wr_res_upper) res_upper_r <= reg_wdata;
  end

  // Resource bounds and pointers keep bits 15:1 only
  always_ff @(posedge core_clk) begin
    if (wr_res_start) res_start_r <= txrxp_res(reg_wdata);
    if (wr_res_end) res_end_r <= txrxp_res(reg_wdata);
    if (wr_res_write) res_write_r <= txrxp_res(reg_wdata);
    if (wr_res_read) res_read_r <= txrxp_res(reg_wdata);
    else if (resource_fetched) res_read_r <= res_read_nxt;
  end

  // Threshold: hardware reset loads the default, soft reset leaves it
  always_ff @(posedge core_clk) begin
    if (reset) eob_count_r <= txrxp_pkg::TXRXP_EOB_RESET;
    else if (wr_eob) eob_count_r <= reg_wdata;
  end

  ////////////////////////////////////////////////////////////////////////
  // Address formation
  ////////////////////////////////////////////////////////////////////////

  // Read pointer steps one descriptor and wraps from end back to start
  assign res_read_nxt = ((res_read_r + txrxp_pkg::TXRXP_RES_STEP) == res_end_r) ?
                        res_start_r : res_read_r + txrxp_pkg::TXRXP_RES_STEP;

  // Lower half of the resource address chosen by the DMA
  assign res_lower = (resource_sel == 2'h0) ? res_start_r :
                     (resource_sel == 2'h1) ? res_end_r :
                     (resource_sel == 2'h2) ? res_read_r : res_write_r;

  // Full 32-bit addresses; areas of 32k words anywhere in memory
  assign tx_desc_addr  = txrxp_join(tx_upper_r, tx_current_r);
  assign rx_desc_addr  = txrxp_join(rx_upper_r, rx_current_r);
  assign resource_addr = txrxp_join(res_upper_r, res_lower);
  assign tx_list_end   = tx_current_r[txrxp_pkg::TXRXP_LIST_END_BIT];
  assign rx_list_end   = rx_current_r[txrxp_pkg::TXRXP_LIST_END_BIT];
  // Pointers equal means no descriptor left to fetch
  assign resource_empty = (res_read_r == res_write_r);

  ////////////////////////////////////////////////////////////////////////
  // End-of-packet decision
  ////////////////////////////////////////////////////////////////////////

  // Compare threshold against words left after the packet
  assign keep_area = (eob_count_r <= remain_r);
  assign next_area = (state_r == TXRXP_CHECK) && !keep_area;

  // Next-state selection for the decision sequence
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      TXRXP_IDLE: begin
        if (pkt_received) state_nxt = TXRXP_CHECK;
      end
      TXRXP_CHECK: begin
        state_nxt = keep_area ? TXRXP_IDLE : TXRXP_FETCH;
      end
      TXRXP_FETCH: begin
        state_nxt = TXRXP_IDLE;
      end
      default: begin
        state_nxt = TXRXP_IDLE;
      end
    endcase
  end

  // Sequencer state, latched word count and flags
  always_ff @(posedge core_clk) begin
    if (reset || soft_reset) begin
      state_r    <= TXRXP_IDLE;
      last_pkt_r <= 1'b0;
      fetch_r    <= 1'b0;
      remain_r   <= txrxp_pkg::TXRXP_ZERO16;
    end else begin
      state_r    <= state_nxt;
      fetch_r    <= next_area;
      if (pkt_received) remain_r <= remaining_buffer_words;
      if (next_area) last_pkt_r <= 1'b1;
      else if (pkt_received) last_pkt_r <= 1'b0;
    end
  end

  assign last_packet_in_buffer_flag = last_pkt_r;
  assign fetch_resource             = fetch_r;

  ////////////////////////////////////////////////////////////////////////
  // Sequence counters
  ////////////////////////////////////////////////////////////////////////

  // Packet and area counters; soft reset has no effect on them
  txrxp_seq_count u_seq (
    .core_clk  (core_clk),
    .reset     (reset),
    .wr_en     (seq_wr),
    .wr_data   (reg_wdata),
    .pkt_done  (pkt_received),
    .next_area (next_area),
    .seq_value (seq_value)
  );

  ////////////////////////////////////////////////////////////////////////
  // Read path
  ////////////////////////////////////////////////////////////////////////

  // Read mux; unmapped offsets read zero
  always_comb begin
    case (reg_addr)
      txrxp_pkg::TXRXP_OFF_TX_UPPER:   rdata_nxt = tx_upper_r;
      txrxp_pkg::TXRXP_OFF_TX_CURRENT: rdata_nxt = tx_current_r;
      txrxp_pkg::TXRXP_OFF_RX_UPPER:   rdata_nxt = rx_upper_r;
      txrxp_pkg::TXRXP_OFF_RX_CURRENT: rdata_nxt = rx_current_r;
      txrxp_pkg::TXRXP_OFF_EOB_COUNT:  rdata_nxt = eob_count_r;
      txrxp_pkg::TXRXP_OFF_RES_UPPER:  rdata_nxt = res_upper_r;
      txrxp_pkg::TXRXP_OFF_RES_START:  rdata_nxt = res_start_r;
      txrxp_pkg::TXRXP_OFF_RES_END:    rdata_nxt = res_end_r;
      txrxp_pkg::TXRXP_OFF_RES_READ:   rdata_nxt = res_read_r;
      txrxp_pkg::TXRXP_OFF_RES_WRITE:  rdata_nxt = res_write_r;
      txrxp_pkg::TXRXP_OFF_SEQUENCE:   rdata_nxt = seq_value;
      txrxp_pkg::TXRXP_OFF_STATUS:     rdata_nxt = {13'h0000, resource_empty,
                                                    fetch_r, last_pkt_r};
      default:                         rdata_nxt = txrxp_pkg::TXRXP_ZERO16;
    endcase
  end

  // Read data stands in the cycle after the read strobe only
  always_ff @(posedge core_clk) begin
    if (reset) rdata_r <= txrxp_pkg::TXRXP_ZERO16;
    else if (reg_rd) rdata_r <= rdata_nxt;
    else rdata_r <= txrxp_pkg::TXRXP_ZERO16;
  end

  assign reg_rdata = rdata_r;
endmodule

// ### core/txrxp_pkg.sv
// Package: register offsets, reset values and field positions for the descriptor pointer block
package txrxp_pkg;
  // Register offsets on the plain register port
  localparam logic [4:0] TXRXP_OFF_TX_UPPER   = 5'h00;
  localparam logic [4:0] TXRXP_OFF_TX_CURRENT = 5'h01;
  localparam logic [4:0] TXRXP_OFF_RX_UPPER   = 5'h02;
  localparam logic [4:0] TXRXP_OFF_RX_CURRENT = 5'h03;
  localparam logic [4:0] TXRXP_OFF_EOB_COUNT  = 5'h04;
  localparam logic [4:0] TXRXP_OFF_RES_UPPER  = 5'h05;
  localparam logic [4:0] TXRXP_OFF_RES_START  = 5'h06;
  localparam logic [4:0] TXRXP_OFF_RES_END    = 5'h07;
  localparam logic [4:0] TXRXP_OFF_RES_READ   = 5'h08;
  localparam logic [4:0] TXRXP_OFF_RES_WRITE  = 5'h09;
  localparam logic [4:0] TXRXP_OFF_SEQUENCE   = 5'h0a;
  localparam logic [4:0] TXRXP_OFF_STATUS     = 5'h0b;
  // Reset values
  localparam logic [15:0] TXRXP_EOB_RESET     = 16'h02f8;
  localparam logic [15:0] TXRXP_SEQ_RESET     = 16'h0000;
  localparam logic [15:0] TXRXP_ZERO16        = 16'h0000;
  // Field positions
  localparam int TXRXP_LIST_END_BIT  = 0;
  localparam int TXRXP_ALIGN_BIT     = 1;
  localparam int TXRXP_BUF_SEQ_LSB   = 8;
  localparam int TXRXP_PKT_SEQ_LSB   = 0;
  // Mask that clears the unused address bit 0 of the resource registers
  localparam logic [15:0] TXRXP_RES_MASK = 16'hfffe;
  // Step for the resource read pointer, one descriptor of four words
  localparam logic [15:0] TXRXP_RES_STEP = 16'h0008;
endpackage

// ### core/txrxp_seq_count.sv
// Receive sequence counter: buffer-area and packet counters, each modulo 256
`timescale 1ns/1ps
module txrxp_seq_count (
  input  wire logic        core_clk,
  input  wire logic        reset,
  input  wire logic        wr_en,
  input  wire logic [15:0] wr_data,
  input  wire logic        pkt_done,
  input  wire logic        next_area,
  output logic      [15:0] seq_value
);
  logic [7:0] buf_seq_r;
  logic [7:0] pkt_seq_r;
  logic [7:0] buf_seq_nxt;
  logic [7:0] pkt_seq_nxt;

  // Moving to a new area clears packet count and bumps area count
  assign buf_seq_nxt = next_area ? buf_seq_r + 8'h01 : buf_seq_r;
  assign pkt_seq_nxt = next_area ? 8'h00 :
                       (pkt_done ? pkt_seq_r + 8'h01 : pkt_seq_r);

  // Hardware reset or a write loads the counters; hardware events win over the write
  always_ff @(posedge core_clk) begin
    if (reset) begin
      buf_seq_r <= txrxp_pkg::TXRXP_SEQ_RESET[15:8];
      pkt_seq_r <= txrxp_pkg::TXRXP_SEQ_RESET[7:0];
    end else if (wr_en && !(pkt_done || next_area)) begin
      buf_seq_r <= wr_data[15:8];
      pkt_seq_r <= wr_data[7:0];
    end else begin
      buf_seq_r <= buf_seq_nxt;
      pkt_seq_r <= pkt_seq_nxt;
    end
  end

  assign seq_value = {buf_seq_r, pkt_seq_r};
endmodule

// ### bench/txrxp_chk.sv
// Checker: port-level assertions for the descriptor pointer block
`timescale 1ns/1ps
module txrxp_chk (
  input wire logic        core_clk,
  input wire logic        reset,
  input wire logic [4:0]  reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic        tx_desc_advance,
  input wire logic        rx_desc_advance,
  input wire logic        pkt_received,
  input wire logic [31:0] tx_desc_addr,
  input wire logic        tx_list_end,
  input wire logic [31:0] rx_desc_addr,
  input wire logic [31:0] resource_addr,
  input wire logic        last_packet_in_buffer_flag,
  input wire logic        fetch_resource
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  ////////////////////////////////////////////////////////////////////////////////
  // A write to the current transmit register shows on the address and marker
  property p_tx_cur;
    reg_wr && reg_addr == txrxp_pkg::TXRXP_OFF_TX_CURRENT && !tx_desc_advance |=>
      tx_desc_addr[15:1] == $past(reg_wdata[15:1]) && tx_list_end == $past(reg_wdata[0]);
  endproperty
  a_tx_cur: assert property (p_tx_cur) else $error("tx address not from current reg");
  property p_rx_cur;
    reg_wr && reg_addr == txrxp_pkg::TXRXP_OFF_RX_CURRENT && !rx_desc_advance |=>
      rx_desc_addr[15:1] == $past(reg_wdata[15:1]);
  endproperty
  a_rx_cur: assert property (p_rx_cur) else $error("rx address not from current reg");
  property p_rx_up;
    reg_wr && reg_addr == txrxp_pkg::TXRXP_OFF_RX_UPPER |=>
      rx_desc_addr[31:16] == $past(reg_wdata);
  endproperty
  a_rx_up: assert property (p_rx_up) else $error("rx upper half wrong");
  property p_tx_b0;
    tx_desc_addr[0] == 1'b0 && rx_desc_addr[0] == 1'b0;
  endproperty
  a_tx_b0: assert property (p_tx_b0) else $error("descriptor address bit 0 set");
  property p_res_b0;
    resource_addr[0] == 1'b0;
  endproperty
  a_res_b0: assert property (p_res_b0) else $error("resource address bit 0 set");
  // Fetch request is a single pulse that comes with the last-packet flag
  property p_fetch_one;
    fetch_resource |=> !fetch_resource;
  endproperty
  a_fetch_one: assert property (p_fetch_one) else $error("fetch pulse too long");
  property p_fetch_flag;
    fetch_resource |-> last_packet_in_buffer_flag;
  endproperty
  a_fetch_flag: assert property (p_fetch_flag) else $error("fetch without flag");
  property p_fetch_cause;
    fetch_resource |-> $past(pkt_received, 1) || $past(pkt_received, 2)
      || $past(pkt_received, 3);
  endproperty
  a_fetch_cause: assert property (p_fetch_cause) else $error("fetch without packet");
  property p_rdata_idle;
    !reg_rd |=> reg_rdata == 16'h0000;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside slot");
  // Main scenarios
  c_fetch: cover property (fetch_resource);
  c_pkt: cover property (pkt_received && !last_packet_in_buffer_flag);
  c_tx: cover property (reg_wr && reg_addr == txrxp_pkg::TXRXP_OFF_TX_CURRENT);
endmodule
////////////////////////////////////////////////////////////////////////////////
bind txrxp_pointers txrxp_chk u_chk (.*);

// ### bench/txrxp_dma_model.sv
// Partner model: receive side of the DMA reporting finished packets
`timescale 1ns/1ps
module txrxp_dma_model (
  input  wire logic        core_clk,
  input  wire logic        reset,
  input  wire logic        start,
  input  wire logic [15:0] words,
  output logic             pkt_received,
  output logic      [15:0] remaining_buffer_words
);
  // One pulse per request; word count only valid beside it, scrambled otherwise
  always_ff @(posedge core_clk) begin
    if (reset) begin
      pkt_received           <= 1'b0;
      remaining_buffer_words <= 16'h0000;
    end else begin
      pkt_received <= start;
      remaining_buffer_words <= start ? words : ~remaining_buffer_words;
    end
  end
endmodule

// ### bench/tb_top.sv
// Testbench: register, pointer, sequence and reset scenarios
`timescale 1ns/1ps
module tb_top;
  logic        core_clk, reset, soft_reset, reg_wr, reg_rd, start;
  logic [4:0]  reg_addr;
  logic [15:0] reg_wdata, words, reg_rdata, remaining_buffer_words, tx_desc_next, rx_desc_next;
  logic        tx_desc_advance, rx_desc_advance, resource_fetched, pkt_received;
  logic [1:0]  resource_sel;
  logic [31:0] tx_desc_addr, rx_desc_addr, resource_addr;
  logic        tx_list_end, rx_list_end, last_pkt, fetch_resource, resource_empty;
  int          errors, tests_run, fetch_cnt;
  logic [15:0] vals [0:10] = '{16'h1234, 16'h0a01, 16'h5678, 16'h0b04, 16'h02f8, 16'h9abc,
                               16'h0101, 16'h0111, 16'h0101, 16'h0109, 16'h0000};
  ////////////////////////////////////////////////////////////////////////////////
  txrxp_pointers u_dut (.core_clk(core_clk), .reset(reset), .soft_reset(soft_reset),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .pkt_received(pkt_received),
    .remaining_buffer_words(remaining_buffer_words), .tx_desc_advance(tx_desc_advance),
    .tx_desc_next(tx_desc_next), .rx_desc_advance(rx_desc_advance),
    .rx_desc_next(rx_desc_next), .resource_fetched(resource_fetched),
    .resource_sel(resource_sel), .tx_desc_addr(tx_desc_addr), .tx_list_end(tx_list_end),
    .rx_desc_addr(rx_desc_addr), .rx_list_end(rx_list_end), .resource_addr(resource_addr),
    .last_packet_in_buffer_flag(last_pkt), .fetch_resource(fetch_resource),
    .resource_empty(resource_empty));
  txrxp_dma_model u_dma (.core_clk(core_clk), .reset(reset), .start(start), .words(words),
    .pkt_received(pkt_received), .remaining_buffer_words(remaining_buffer_words));
  ////////////////////////////////////////////////////////////////////////////////
  // Clock and fetch pulse counter
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) if (fetch_resource === 1'b1) fetch_cnt++;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      errors++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rchk(input string n, input logic [4:0] a, input logic [15:0] e);
    @(posedge core_clk);
    reg_rd <= 1'b1; reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 chk(n, {16'h0000, e}, {16'h0000, reg_rdata});
  endtask
  task automatic pkt(input logic [15:0] w, input logic [15:0] seq, input logic flag);
    @(posedge core_clk);
    start <= 1'b1; words <= w;
    @(posedge core_clk);
    start <= 1'b0;
    repeat (6) @(posedge core_clk);
    #1 chk("last_pkt", {31'h0, flag}, {31'h0, last_pkt});
    rchk("sequence", txrxp_pkg::TXRXP_OFF_SEQUENCE, seq);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_reset_values();
    rchk("eob", txrxp_pkg::TXRXP_OFF_EOB_COUNT, 16'h02f8);
    rchk("seq", txrxp_pkg::TXRXP_OFF_SEQUENCE, 16'h0000);
  endtask
  task automatic t_registers();
    for (int i = 0; i <= 10; i++) wr(i[4:0], vals[i]);
    for (int i = 0; i <= 10; i++)
      rchk("reg", i[4:0], (i >= 6 && i <= 9) ? (vals[i] & txrxp_pkg::TXRXP_RES_MASK) : vals[i]);
    rchk("unmapped", 5'h1f, 16'h0000);
    chk("tx_addr", 32'h12340a00, tx_desc_addr);
    chk("tx_end", 32'h1, {31'h0, tx_list_end});
    chk("rx_addr", 32'h56780b04, rx_desc_addr);
    chk("rx_end", 32'h0, {31'h0, rx_list_end});
    for (int s = 0; s < 4; s++) begin
      @(posedge core_clk) resource_sel <= s[1:0];
      @(posedge core_clk) #1;
      chk("res_addr", {16'h9abc, vals[6 + s] & txrxp_pkg::TXRXP_RES_MASK}, resource_addr);
    end
  endtask
  task automatic t_resource();
    @(posedge core_clk) resource_fetched <= 1'b1;
    @(posedge core_clk) resource_fetched <= 1'b0;
    rchk("read_ptr", txrxp_pkg::TXRXP_OFF_RES_READ, 16'h0108);
    chk("empty", 32'h1, {31'h0, resource_empty});
  endtask
  task automatic t_packets();
    pkt(16'h02f8, 16'h0001, 1'b0);
    pkt(16'h02f7, 16'h0100, 1'b1);
    chk("fetch_cnt", 32'd1, fetch_cnt);
    wr(txrxp_pkg::TXRXP_OFF_SEQUENCE, 16'h00ff);
    pkt(16'h0300, 16'h0000, 1'b0);
    wr(txrxp_pkg::TXRXP_OFF_SEQUENCE, 16'hff05);
    pkt(16'h0000, 16'h0000, 1'b1);
    wr(txrxp_pkg::TXRXP_OFF_EOB_COUNT, 16'h0010);
    pkt(16'h0010, 16'h0001, 1'b0);
  endtask
  task automatic t_advance();
    @(posedge core_clk);
    tx_desc_advance <= 1'b1; tx_desc_next <= 16'h0c00;
    rx_desc_advance <= 1'b1; rx_desc_next <= 16'h0d01;
    @(posedge core_clk);
    tx_desc_advance <= 1'b0; rx_desc_advance <= 1'b0;
    @(posedge core_clk) #1;
    chk("tx_adv", 32'h12340c00, tx_desc_addr);
    chk("rx_adv", {32'h56780d00}, rx_desc_addr);
    chk("rx_end", 32'h1, {31'h0, rx_list_end});
  endtask
  task automatic t_resets();
    @(posedge core_clk) soft_reset <= 1'b1;
    @(posedge core_clk) soft_reset <= 1'b0;
    rchk("soft_eob", txrxp_pkg::TXRXP_OFF_EOB_COUNT, 16'h0010);
    rchk("soft_seq", txrxp_pkg::TXRXP_OFF_SEQUENCE, 16'h0001);
    @(posedge core_clk) reset <= 1'b1;
    repeat (2) @(posedge core_clk);
    reset <= 1'b0;
    rchk("hard_txup", txrxp_pkg::TXRXP_OFF_TX_UPPER, 16'h1234);
    rchk("hard_rxcur", txrxp_pkg::TXRXP_OFF_RX_CURRENT, 16'h0d01);
    rchk("hard_eob", txrxp_pkg::TXRXP_OFF_EOB_COUNT, 16'h02f8);
    rchk("hard_seq", txrxp_pkg::TXRXP_OFF_SEQUENCE, 16'h0000);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic conclude();
    if (errors == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Main sequence
  initial begin
    {reset, soft_reset, reg_wr, reg_rd, start, tx_desc_advance} = 6'h20;
    {rx_desc_advance, resource_fetched, resource_sel, reg_addr} = '0;
    {reg_wdata, words, tx_desc_next, rx_desc_next} = '0;
    {errors, tests_run, fetch_cnt} = '0;
    repeat (5) @(posedge core_clk);
    reset <= 1'b0;
    t_reset_values();
    t_registers();
    t_resource();
    t_packets();
    t_advance();
    t_resets();
    conclude();
  end
  // Watchdog
  initial begin
    #100000;
    errors++;
    conclude();
  end
endmodule
